//--- src/dtc_controller.sv
// Controller end: APB register slave driving the termination link
`default_nettype none
module dtc_controller
  import dtc_pkg::*;
(
  input  wire logic        CLK_SYS_I,
  input  wire logic        RESETN_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic [31:0]      PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  dtc_link_if.controller   link
);

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  logic        setup;
  logic        wr_acc;
  logic        hit_mr1;
  logic        hit_mr2;
  logic        hit_lat;
  logic        hit_cmd;
  logic        hit_st;
  logic        mapped;
  logic [31:0] rdata;

  assign setup   = PSEL_I & ~PENABLE_I;
  assign wr_acc  = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I & mapped;
  assign hit_mr1 = PADDR_I == A_MR1;
  assign hit_mr2 = PADDR_I == A_MR2;
  assign hit_lat = PADDR_I == A_LAT;
  assign hit_cmd = PADDR_I == A_CMD;
  assign hit_st  = PADDR_I == A_STAT;
  assign mapped  = hit_mr1 | hit_mr2 | hit_lat | hit_cmd | hit_st;

  logic [MR_W-1:0] mr1_reg;
  logic [MR_W-1:0] mr2_reg;
  logic [3:0]      cwl_reg;
  logic [3:0]      al_reg;
  logic            dll_off_reg;
  logic            pin_req_reg;
  logic            err_reg;
  logic [2:0]      hold_reg;

  always_comb begin
    if (hit_mr1) begin
      rdata = {16'h0000, mr1_reg};
    end else if (hit_mr2) begin
      rdata = {16'h0000, mr2_reg};
    end else if (hit_lat) begin
      rdata = {23'h000000, dll_off_reg, al_reg, cwl_reg};
    end else if (hit_cmd) begin
      rdata = {31'h00000000, pin_req_reg};
    end else if (hit_st) begin
      rdata = {28'h0000000, link.mr2[WR_HI] | link.mr2[WR_LO], err_reg,
               hold_reg != 3'h0, link.term_control_pin};
    end else begin
      rdata = 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Programming checks

  logic [2:0] new_nom;
  logic [1:0] new_wr;
  logic       mr1_ok;
  logic       mr2_ok;
  logic       wr_req;
  logic       wr_bad;
  logic       wr_go;
  logic       dll_set;

  assign new_nom = {PWDATA_I[NOM_B2], PWDATA_I[NOM_B1], PWDATA_I[NOM_B0]};
  assign new_wr  = {PWDATA_I[WR_HI], PWDATA_I[WR_LO]};
  assign mr1_ok  = new_nom < NOM_RSV0;
  assign mr2_ok  = new_wr != WR_RSV;
  assign dll_set = wr_acc & hit_lat & PWDATA_I[LAT_DLL];
  assign wr_req  = wr_acc & hit_cmd & PWDATA_I[CMD_WR];
  // Nominal used during writes must be one of the weaker values
  assign wr_bad  = ({link.mr2[WR_HI], link.mr2[WR_LO]} == WR_OFF)
                 & ({mr1_reg[NOM_B2], mr1_reg[NOM_B1], mr1_reg[NOM_B0]} >= NOM_RZQ12)
                 & ({mr1_reg[NOM_B2], mr1_reg[NOM_B1], mr1_reg[NOM_B0]} <= NOM_RZQ8);
  assign wr_go   = wr_req & ~wr_bad;

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      mr1_reg     <= '0;
      mr2_reg     <= '0;
      cwl_reg     <= CWL_RST;
      al_reg      <= '0;
      dll_off_reg <= 1'b0;
      pin_req_reg <= 1'b0;
    end else begin
      if (wr_acc & hit_mr1 & mr1_ok) begin
        mr1_reg <= PWDATA_I[MR_W-1:0];
      end
      if (wr_acc & hit_mr2 & mr2_ok) begin
        mr2_reg <= PWDATA_I[MR_W-1:0];
        if (dll_off_reg) begin
          mr2_reg[WR_HI:WR_LO] <= WR_OFF;
        end
      end else if (dll_set) begin
        mr2_reg[WR_HI:WR_LO] <= WR_OFF;
      end
      if (wr_acc & hit_lat) begin
        cwl_reg     <= PWDATA_I[3:0];
        al_reg      <= PWDATA_I[LAT_AL_LO+3:LAT_AL_LO];
        dll_off_reg <= PWDATA_I[LAT_DLL];
      end
      if (wr_acc & hit_cmd) begin
        pin_req_reg <= PWDATA_I[CMD_PIN];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error flag, set wins over clear

  logic err_set;
  logic err_clr;

  assign err_set = (wr_acc & hit_mr1 & ~mr1_ok) | (wr_acc & hit_mr2 & ~mr2_ok)
                 | (wr_req & wr_bad);
  assign err_clr = wr_acc & hit_st & PWDATA_I[ST_ERR];

  ////////////////////////////////////////////////////////////////////////////
  // Pin hold and write strobe

  // Counts from the edge the controller drives the pin or write
  logic       rise;
  logic [2:0] wr_hold;
  logic [2:0] load;
  logic [2:0] hold_next;
  logic       pin_next;

  assign rise      = pin_req_reg & ~link.term_control_pin;
  assign wr_hold   = (PWDATA_I[CMD_BC4] ? HOLD_SHORT : HOLD_LONG) - 3'h1;
  assign load      = (wr_go & (link.term_control_pin | rise)) ? wr_hold
                   : rise ? HOLD_SHORT - 3'h1 : 3'h0;
  assign hold_next = (load > hold_reg) ? load
                   : (hold_reg != 3'h0) ? hold_reg - 3'h1 : 3'h0;
  // No upper bound on high time, so a tied-high pin is fine
  assign pin_next  = pin_req_reg | (link.term_control_pin & hold_reg != 3'h0);

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      hold_reg              <= '0;
      err_reg               <= 1'b0;
      link.term_control_pin <= 1'b0;
      link.write_cmd        <= 1'b0;
      link.write_bc4        <= 1'b0;
      PRDATA_O              <= '0;
      PREADY_O              <= 1'b0;
      PSLVERR_O             <= 1'b0;
    end else begin
      hold_reg              <= hold_next;
      err_reg               <= err_set | (err_reg & ~err_clr);
      link.term_control_pin <= pin_next;
      link.write_cmd        <= wr_go;
      link.write_bc4        <= wr_go & PWDATA_I[CMD_BC4];
      PRDATA_O              <= setup ? rdata : PRDATA_O;
      PREADY_O              <= setup;
      PSLVERR_O             <= setup & ~mapped;
    end
  end

  assign link.mr1 = mr1_reg;
  assign link.mr2 = mr2_reg;
  assign link.cwl = cwl_reg;
  assign link.al  = al_reg;

endmodule : dtc_controller
`default_nettype wire

//--- src/dtc_pkg.sv
// Shared constants for the dynamic termination control ends
`default_nettype none
package dtc_pkg;
  localparam int MR_W       = 16;
  localparam int LAT_W      = 5;
  localparam int HIST_D     = 32;
  localparam int NOM_B2     = 9;
  localparam int NOM_B1     = 6;
  localparam int NOM_B0     = 2;
  localparam int WR_HI      = 10;
  localparam int WR_LO      = 9;
  localparam logic [LAT_W-1:0] LAT_OFS = 5'h02;
  localparam logic [LAT_W-1:0] LAT_MIN = 5'h01;
  localparam logic [LAT_W-1:0] LAT_MAX = 5'h1a;
  localparam logic [LAT_W-1:0] BC4_EXT = 5'h04;
  localparam logic [LAT_W-1:0] BL8_EXT = 5'h06;
  localparam logic [2:0] HOLD_SHORT   = 3'h4;
  localparam logic [2:0] HOLD_LONG    = 3'h6;
  localparam logic [2:0] NOM_OFF      = 3'h0;
  localparam logic [2:0] NOM_RZQ12    = 3'h4;
  localparam logic [2:0] NOM_RZQ8     = 3'h5;
  localparam logic [2:0] NOM_RSV0     = 3'h6;
  localparam logic [1:0] WR_OFF       = 2'h0;
  localparam logic [1:0] WR_RSV       = 2'h3;
  localparam logic [3:0] CWL_RST      = 4'h5;
  localparam logic [7:0] A_MR1        = 8'h00;
  localparam logic [7:0] A_MR2        = 8'h04;
  localparam logic [7:0] A_LAT        = 8'h08;
  localparam logic [7:0] A_CMD        = 8'h0c;
  localparam logic [7:0] A_STAT       = 8'h10;
  localparam int LAT_AL_LO  = 4;
  localparam int LAT_DLL    = 8;
  localparam int CMD_PIN    = 0;
  localparam int CMD_WR     = 1;
  localparam int CMD_BC4    = 2;
  localparam int ST_ERR     = 2;
endpackage : dtc_pkg
`default_nettype wire

//--- src/dtc_link_if.sv
// Link between the memory controller end and the device end
`default_nettype none
interface dtc_link_if;
  import dtc_pkg::*;
  logic                   term_control_pin;
  logic                   write_cmd;
  logic                   write_bc4;
  logic [MR_W-1:0]        mr1;
  logic [MR_W-1:0]        mr2;
  logic [3:0]             cwl;
  logic [3:0]             al;
  modport device (
    input term_control_pin, write_cmd, write_bc4, mr1, mr2, cwl, al
  );
  modport controller (
    output term_control_pin, write_cmd, write_bc4, mr1, mr2, cwl, al
  );
endinterface : dtc_link_if
`default_nettype wire

//--- src/dtc_device.sv
// Device end: termination on/off timing and nominal/write strength switch
`default_nettype none
module dtc_device
  import dtc_pkg::*;
(
  input  wire logic   CLK_SYS_I,
  input  wire logic   RESETN_I,
  dtc_link_if.device  link,
  output logic        TERM_ON_O,
  output logic        TERM_SEL_WRITE_O,
  output logic [2:0]  TERM_CODE_O,
  output logic        TERM_UNDEF_O,
  output logic        DYN_EN_O,
  output logic        RESERVED_CFG_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode

  logic [2:0]       nom_code;
  logic [1:0]       wr_code;
  logic             dyn_en;
  logic             cfg_rsv;

  assign nom_code = {link.mr1[NOM_B2], link.mr1[NOM_B1], link.mr1[NOM_B0]};
  assign wr_code  = {link.mr2[WR_HI], link.mr2[WR_LO]};
  assign dyn_en   = link.mr2[WR_HI] | link.mr2[WR_LO];
  assign cfg_rsv  = (nom_code >= NOM_RSV0) | (wr_code == WR_RSV);

  ////////////////////////////////////////////////////////////////////////////
  // Latency

  // Clamped so the longest return index stays inside the history depth
  logic [LAT_W-1:0] lat_raw;
  logic [LAT_W-1:0] lat;
  logic [LAT_W-1:0] on_idx;
  logic [LAT_W-1:0] bc4_idx;
  logic [LAT_W-1:0] bl8_idx;

  assign lat_raw = LAT_W'({1'b0, link.cwl} + {1'b0, link.al}) - LAT_OFS;
  assign lat     = ({1'b0, link.cwl} + {1'b0, link.al} <= {1'b0, 4'h0} + LAT_OFS)
                   ? LAT_MIN
                   : (lat_raw > LAT_MAX) ? LAT_MAX : lat_raw;
  assign on_idx  = lat - LAT_MIN;
  assign bc4_idx = on_idx + BC4_EXT;
  assign bl8_idx = on_idx + BL8_EXT;

  ////////////////////////////////////////////////////////////////////////////
  // Histories of registered inputs

  logic [HIST_D-1:0] pin_hist_reg;
  logic [HIST_D-1:0] wr_hist_reg;
  logic [HIST_D-1:0] bc4_hist_reg;
  logic              wr_take;

  // Writes without dynamic mode never enter the history
  assign wr_take = link.write_cmd & dyn_en;

  dtc_hist i_dtc_hist_pin (
    .CLK_SYS_I (CLK_SYS_I),
    .RESETN_I  (RESETN_I),
    .bit_i     (link.term_control_pin),
    .hist_o    (pin_hist_reg)
  );

  dtc_hist i_dtc_hist_wr (
    .CLK_SYS_I (CLK_SYS_I),
    .RESETN_I  (RESETN_I),
    .bit_i     (wr_take),
    .hist_o    (wr_hist_reg)
  );

  dtc_hist i_dtc_hist_bc4 (
    .CLK_SYS_I (CLK_SYS_I),
    .RESETN_I  (RESETN_I),
    .bit_i     (link.write_bc4),
    .hist_o    (bc4_hist_reg)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Write window tracking

  // A count, not a flag, so overlapping bursts keep the write value
  logic [2:0]       open_reg;
  logic [2:0]       open_next;
  logic             start_hit;
  logic             end_hit;
  logic             pin_late;

  assign start_hit = wr_hist_reg[on_idx];
  assign end_hit   = (wr_hist_reg[bc4_idx] & bc4_hist_reg[bc4_idx])
                   | (wr_hist_reg[bl8_idx] & ~bc4_hist_reg[bl8_idx]);
  assign pin_late  = pin_hist_reg[on_idx];
  assign open_next = open_reg + {2'h0, start_hit} - {2'h0, end_hit};

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      open_reg <= '0;
    end else begin
      open_reg <= open_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strength selection and outputs

  logic             sel_write_next;
  logic [2:0]       code_next;
  logic             on_next;
  logic             undef_next;

  // Dynamic mode dropped mid-burst falls straight back to nominal
  assign sel_write_next = (open_next != 3'h0) & dyn_en;
  assign code_next      = sel_write_next ? {1'b0, wr_code} : nom_code;
  // Pin gates either strength; a zero code means no termination at all
  assign on_next        = pin_late & (code_next != NOM_OFF);
  // One-cycle flag standing for the sub-cycle skew window
  assign undef_next     = sel_write_next != TERM_SEL_WRITE_O;

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      TERM_ON_O        <= 1'b0;
      TERM_SEL_WRITE_O <= 1'b0;
      TERM_CODE_O      <= NOM_OFF;
      TERM_UNDEF_O     <= 1'b0;
      DYN_EN_O         <= 1'b0;
      RESERVED_CFG_O   <= 1'b0;
    end else begin
      TERM_ON_O        <= on_next;
      TERM_SEL_WRITE_O <= sel_write_next;
      TERM_CODE_O      <= code_next;
      TERM_UNDEF_O     <= undef_next;
      DYN_EN_O         <= dyn_en;
      RESERVED_CFG_O   <= cfg_rsv;
    end
  end

endmodule : dtc_device

////////////////////////////////////////////////////////////////////////////
// Shift history of one registered link bit, newest at index 0

// Depth covers the longest latency plus the long burst extension
module dtc_hist
  import dtc_pkg::*;
(
  input  wire logic          CLK_SYS_I,
  input  wire logic          RESETN_I,
  input  wire logic          bit_i,
  output logic [HIST_D-1:0]  hist_o
);

  logic [HIST_D-1:0] hist_reg;
  logic [HIST_D-1:0] hist_next;

  assign hist_next = {hist_reg[HIST_D-2:0], bit_i};
  assign hist_o    = hist_reg;

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      hist_reg <= '0;
    end else begin
      hist_reg <= hist_next;
    end
  end

endmodule : dtc_hist
`default_nettype wire

//--- verification/dtc_sva.sv
// Assertions on the termination link and the device end outputs
`default_nettype none
module dtc_sva
  import dtc_pkg::*;
(
  input wire logic            CLK_SYS_I,
  input wire logic            RESETN_I,
  input wire logic            term_control_pin,
  input wire logic            write_cmd,
  input wire logic            write_bc4,
  input wire logic [MR_W-1:0] mr1,
  input wire logic [MR_W-1:0] mr2,
  input wire logic [3:0]      cwl,
  input wire logic [3:0]      al,
  input wire logic            TERM_ON_O,
  input wire logic            TERM_SEL_WRITE_O,
  input wire logic [2:0]      TERM_CODE_O,
  input wire logic            TERM_UNDEF_O,
  input wire logic            DYN_EN_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESETN_I);
  // Fixed delays only fit the reset latency of 3; other latencies are timed by the bench
  wire       lat3 = (cwl == 4'h5) && (al == 4'h0);
  wire [2:0] nom  = {mr1[NOM_B2], mr1[NOM_B1], mr1[NOM_B0]};
  wire       arm  = write_cmd && lat3 && DYN_EN_O && !TERM_SEL_WRITE_O;
  sequence s_to_write;
    ##4 TERM_SEL_WRITE_O;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  a_dyn_enable: assert property ($stable(mr2) |-> DYN_EN_O == (mr2[WR_HI] | mr2[WR_LO]))
    else $error("dynamic enable does not follow write code");
  a_write_long: assert property (arm && !write_bc4 |->
    s_to_write ##1 TERM_SEL_WRITE_O [*5] ##1 !TERM_SEL_WRITE_O)
    else $error("long burst write window wrong");
  a_write_short: assert property (arm && write_bc4 |->
    s_to_write ##1 TERM_SEL_WRITE_O [*3] ##1 !TERM_SEL_WRITE_O)
    else $error("chopped burst write window wrong");
  a_no_dyn_keep: assert property (write_cmd && !DYN_EN_O && mr2[WR_HI:WR_LO] == WR_OFF
    |-> ##1 !TERM_SEL_WRITE_O [*8])
    else $error("write strength selected without dynamic mode");
  a_undef_pulse: assert property (TERM_UNDEF_O == $changed(TERM_SEL_WRITE_O))
    else $error("undefined flag not tied to strength switch");
  a_code_write: assert property (TERM_SEL_WRITE_O && $stable(mr2)
    |-> TERM_CODE_O == {1'b0, mr2[WR_HI], mr2[WR_LO]})
    else $error("write code wrong");
  a_code_nom: assert property (!TERM_SEL_WRITE_O && !$past(TERM_SEL_WRITE_O) && $stable(mr1)
    |-> TERM_CODE_O == nom)
    else $error("nominal code wrong");
  a_pin_hold: assert property ($rose(term_control_pin) |-> term_control_pin [*4])
    else $error("pin dropped before short hold");
  a_hold_long: assert property (write_cmd && term_control_pin && !write_bc4
    |-> term_control_pin [*6])
    else $error("pin dropped before long hold");
  a_term_on: assert property ($rose(term_control_pin) && lat3 && nom != NOM_OFF
    && !TERM_SEL_WRITE_O && $stable(mr1) |-> ##4 TERM_ON_O)
    else $error("termination not on after latency");
endmodule : dtc_sva
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the controller and device ends joined by the link
`default_nettype none
module testbench
  import dtc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, resetn, psel, penable, pwrite, pready, pslverr, err;
  logic        term_on, sel_wr, undef, dyn_en, rsv;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, last, v;
  logic [2:0]  code, cw;
  integer      seed = 28, n_errors = 0, n_compared = 0, cycles = 0;
  dtc_link_if link ();
  dtc_controller i_dtc_controller (.CLK_SYS_I(clk), .RESETN_I(resetn), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .link(link));
  dtc_device i_dtc_device (.CLK_SYS_I(clk), .RESETN_I(resetn), .link(link),
    .TERM_ON_O(term_on), .TERM_SEL_WRITE_O(sel_wr), .TERM_CODE_O(code),
    .TERM_UNDEF_O(undef), .DYN_EN_O(dyn_en), .RESERVED_CFG_O(rsv));
  dtc_sva i_dtc_sva (.CLK_SYS_I(clk), .RESETN_I(resetn), .term_control_pin(link.term_control_pin),
    .write_cmd(link.write_cmd), .write_bc4(link.write_bc4), .mr1(link.mr1), .mr2(link.mr2),
    .cwl(link.cwl), .al(link.al), .TERM_ON_O(term_on), .TERM_SEL_WRITE_O(sel_wr),
    .TERM_CODE_O(code), .TERM_UNDEF_O(undef), .DYN_EN_O(dyn_en));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      wrap_up;
    end
  end
  task automatic wrap_up;
    if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // One idle edge after each transfer, so psel is never assigned twice in a step
  // Waits on pready as long as it takes; only the cycle ceiling ends a hang
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  function automatic logic [31:0] nom_bits(input logic [2:0] c, input logic [31:0] r);
    nom_bits         = r & 32'h0000_fdbb;
    nom_bits[NOM_B2] = c[2];
    nom_bits[NOM_B1] = c[1];
    nom_bits[NOM_B0] = c[0];
  endfunction : nom_bits
  function automatic int burst_len(input logic bc4);
    burst_len = bc4 ? 4 : 6;
  endfunction : burst_len
  // Counts write-selected cycles and the first edge with termination on
  task automatic watch(input int len, output int n, output int k);
    n = 0;
    k = 0;
    for (int t = 1; t <= len; t++) begin
      @(posedge clk);
      if (sel_wr === 1'b1) n = n + 1;
      if (sel_wr === 1'b1) cw = code;
      if (term_on === 1'b1 && k == 0) k = t;
    end
  endtask : watch
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int n, k, c, lat;
    {psel, penable, pwrite, paddr, pwdata, last} = '0;
    resetn = 1'b0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      v = nom_bits(i[2:0], $random(seed));
      apb(1'b1, A_MR1, v);
      if (i < 6) last = v;
      apb(1'b0, A_MR1, 32'h0);
      check(rd, last);
      apb(1'b0, A_STAT, 32'h0);
      check(rd[ST_ERR], i >= 6);
      apb(1'b1, A_STAT, 32'h4);
    end
    for (int j = 0; j < 4; j++) begin
      v = ($random(seed) & 32'h0000_f9ff) | (j << WR_LO);
      apb(1'b1, A_MR2, v);
      if (j < 3) last = v;
      apb(1'b0, A_MR2, 32'h0);
      check(rd, last);
      apb(1'b0, A_STAT, 32'h0);
      check({rd[3], rd[ST_ERR]}, {j != 0, j == 3});
      apb(1'b1, A_STAT, 32'h4);
    end
    check(rsv, 1'b0);
    apb(1'b1, 8'h14, $random(seed));
    check(err, 1'b1);
    apb(1'b1, A_MR1, nom_bits(3'h1, 32'h0));
    for (int i = 0; i < 4; i++) begin
      c = (i >> 1) + 1;
      apb(1'b1, A_MR2, c << WR_LO);
      // Later passes raise the pin first and drop its request with the write
      if (i[1]) apb(1'b1, A_CMD, 32'h1);
      apb(1'b1, A_CMD, {29'h0, i[0], 1'b1, !i[1]});
      watch(16, n, k);
      check(n, burst_len(i[0]));
      check(cw, c);
      check(term_on, !i[1]);
      apb(1'b1, A_CMD, 32'h0);
      repeat (($random(seed) & 3) + 8) @(posedge clk);
    end
    apb(1'b1, A_MR2, 32'h0);
    apb(1'b1, A_CMD, 32'h2);
    watch(12, n, k);
    check(n, 0);
    apb(1'b1, A_MR1, nom_bits(NOM_RZQ12, 32'h0));
    apb(1'b1, A_CMD, 32'h2);
    apb(1'b0, A_STAT, 32'h0);
    check(rd[ST_ERR], 1'b1);
    apb(1'b1, A_STAT, 32'h4);
    apb(1'b1, A_MR2, 32'h400);
    apb(1'b1, A_LAT, 32'h105);
    apb(1'b0, A_MR2, 32'h0);
    check(rd[10:9], 2'h0);
    c = ($random(seed) & 3) + 6;
    lat = ($random(seed) & 3) + c - 2;
    apb(1'b1, A_LAT, (lat - c + 2) << 4 | c);
    apb(1'b1, A_MR1, nom_bits(3'h2, 32'h0));
    apb(1'b1, A_CMD, 32'h1);
    watch(20, n, k);
    // One edge for the device to register the pin, one for the bench to see the registered output
    check(k, lat + 2);
    apb(1'b1, A_CMD, 32'h0);
    k = 0;
    while (term_on === 1'b1) begin
      @(posedge clk);
      k = k + 1;
    end
    check(k, lat + 2);
    wrap_up;
  end
endmodule : testbench
`default_nettype wire
